// [design/pst_defs.svh]
// Purpose: Constants for the power-up self-test fault reporter.
// Assumes: Clock of 20 MHz, synchronous active-high reset.
// Notes: Timing counts derive from times held in milliseconds.
// Notes on behaviour
// RL1: Kernel tests run in order: firmware checksum, nonvolatile memory, support chip.
// RL2: A failing kernel test pulses the channel two indicator eight times per frame.
// RL3: Channel one lights only during the pulse numbered as the failing test.
// RL4: Firmware checksum compared with stored value; mismatch gives fault code one.
// RL5: After a firmware fault frame, the device still proceeds to normal operation.
// RL6: Nonvolatile memory test never alters stored calibration or critical data.
// RL7: Nonvolatile memory failure reports code two and loops forever, no link.
// RL8: Corrupt calibration table reloads defaults and flags error in diagnostics.
// RL9: Support chip signature mismatch reports code three and loops until power-off.
// RL10: Settings initialise and the link opens only after all kernel tests pass; the code also opens them after a firmware checksum fault.
// RL11: Mainframe requests self-tests once linked unless its self-tests are disabled.
// RL12: Error index is prefix plus hex block, area, routine, failure mode.
// RL13: Prefix character encodes left, center or right compartment.
// RL14: Front-panel activity during self-test is recorded as a test failure.
// RL15: Per block, keep the first error code and a failure count.
// RL16: New or moved plug-in recalibrates; normal operation only on success.
// RL17: Overload sense and probe data lines are watched during operation.
// RL18: Indicator pulse period and inter-frame pause are fixed visible constants.
`ifndef PST_DEFS_SVH
`define PST_DEFS_SVH

`define PST_CLK_HZ 20000000
`define PST_PULSE_MS 250
`define PST_PAUSE_MS 2000
`define PST_PULSE_CYC ((`PST_CLK_HZ / 1000) * `PST_PULSE_MS)
`define PST_PAUSE_CYC ((`PST_CLK_HZ / 1000) * `PST_PAUSE_MS)
`define PST_PULSES 4'h8
`define PST_CODE_ROM 2'h1
`define PST_CODE_NVM 2'h2
`define PST_CODE_SUP 2'h3
`define PST_CHAR_L 8'h4C
`define PST_CHAR_C 8'h43
`define PST_CHAR_R 8'h52
`define PST_CHAR_Q 8'h3F
`define PST_BLOCK 4'h1
`define PST_AREA_CAL 4'h2
`define PST_AREA_PANEL 4'h9
`define PST_AREA_MON 4'hA
`define PST_CODE_CAL 16'h1231
`define PST_CODE_PANEL 16'h1911

`endif

// [design/pst_pkg.sv]
// Purpose: Types shared by the self-test fault reporter.
// Assumes: Nothing beyond the constants header.
// Notes: States are written out in binary.
package pst_pkg;
  typedef enum logic [3:0] {
    PST_ROM = 4'b0000,
    PST_ROM_WAIT = 4'b0001,
    PST_NVM = 4'b0010,
    PST_NVM_WAIT = 4'b0011,
    PST_SUP = 4'b0100,
    PST_SUP_WAIT = 4'b0101,
    PST_FLASH = 4'b0110,
    PST_INIT = 4'b0111,
    PST_LINK = 4'b1000,
    PST_SELF = 4'b1001,
    PST_RECAL = 4'b1010,
    PST_NORMAL = 4'b1011,
    PST_DIAG = 4'b1100
  } pst_state_t;
  typedef enum logic [1:0] {
    PST_LEFT = 2'b00,
    PST_CENTER = 2'b01,
    PST_RIGHT = 2'b10
  } pst_slot_t;
endpackage

// [design/pst_fault_flasher.sv]
// Purpose: Flashes one fault-code frame on the two channel indicators.
// Assumes: Start is a one-cycle pulse while idle.
// Notes: Done pulses after the inter-frame pause that closes the frame.
`include "pst_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pst_fault_flasher #(
  parameter int PULSE_CYC = `PST_PULSE_CYC,
  parameter int PAUSE_CYC = `PST_PAUSE_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic [1:0] code_i,
  output logic channel_one_indicator_o,
  output logic channel_two_indicator_o,
  output logic busy_o,
  output logic done_o
);
  logic [31:0] tick_q;
  logic [3:0] pulse_q;
  logic [1:0] code_q;
  logic phase_q;
  logic pause_q;

  // Each pulse is one lit half-period and one dark half-period.
  always_ff @(posedge clock_i) begin
    done_o <= 1'b0;
    if (sys_rst_i) begin
      tick_q <= 32'h0000_0000;
      pulse_q <= 4'h0;
      code_q <= 2'h0;
      phase_q <= 1'b0;
      pause_q <= 1'b0;
      busy_o <= 1'b0;
      channel_one_indicator_o <= 1'b0;
      channel_two_indicator_o <= 1'b0;
    end else if (!busy_o) begin
      if (start_i) begin
        busy_o <= 1'b1;
        code_q <= code_i;
        pulse_q <= 4'h1;
        phase_q <= 1'b1;
        tick_q <= 32'h0000_0000;
        channel_two_indicator_o <= 1'b1; // RL2
        channel_one_indicator_o <= (code_i == 2'h1); // RL3
      end
    end else if (pause_q) begin
      if (tick_q == 32'(PAUSE_CYC - 1)) begin // RL18
        pause_q <= 1'b0;
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end else begin
        tick_q <= tick_q + 32'h0000_0001;
      end
    end else if (tick_q == 32'(PULSE_CYC - 1)) begin // RL18
      tick_q <= 32'h0000_0000;
      if (phase_q) begin
        phase_q <= 1'b0;
        channel_two_indicator_o <= 1'b0;
        channel_one_indicator_o <= 1'b0;
      end else if (pulse_q == `PST_PULSES) begin // RL2
        pause_q <= 1'b1;
      end else begin
        phase_q <= 1'b1;
        pulse_q <= pulse_q + 4'h1;
        channel_two_indicator_o <= 1'b1; // RL2
        channel_one_indicator_o <= (pulse_q + 4'h1 == {2'b00, code_q}); // RL3
      end
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// [design/pst_selftest_top.sv]
// Purpose: Power-up kernel test sequencer and self-test fault reporter.
// Assumes: Test engines outside answer each start with done and a verdict.
// Notes: Kernel faults flash the indicators; later faults give index codes.
`include "pst_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pst_selftest_top #(
  parameter int PULSE_CYC = `PST_PULSE_CYC,
  parameter int PAUSE_CYC = `PST_PAUSE_CYC
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic rom_done_i,
  input wire logic [15:0] rom_sum_calc_i,
  input wire logic [15:0] rom_sum_stored_i,
  input wire logic nvm_done_i,
  input wire logic nvm_fail_i,
  input wire logic cal_sum_bad_i,
  input wire logic sup_done_i,
  input wire logic [15:0] sup_signature_i,
  input wire logic [15:0] sup_good_sig_i,
  input wire pst_pkg::pst_slot_t slot_i,
  input wire logic new_config_i,
  input wire logic link_ready_i,
  input wire logic self_req_i,
  input wire logic self_done_i,
  input wire logic self_err_i,
  input wire logic [15:0] self_code_i,
  input wire logic recal_done_i,
  input wire logic recal_ok_i,
  input wire logic panel_activity_i,
  input wire logic overload_sense_i,
  input wire logic probe_data_i,
  output logic rom_start_o,
  output logic nvm_start_o,
  output logic nvm_preserve_o,
  output logic sup_start_o,
  output logic cal_reload_o,
  output logic settings_init_o,
  output logic link_enable_o,
  output logic self_run_o,
  output logic recal_start_o,
  output logic normal_o,
  output logic diag_menu_o,
  output logic channel_one_indicator_o,
  output logic channel_two_indicator_o,
  output logic err_valid_o,
  output logic [7:0] err_prefix_o,
  output logic [15:0] err_code_o,
  output logic [7:0] err_count_o,
  output logic overload_seen_o,
  output logic probe_seen_o
);
  import pst_pkg::*;

  pst_state_t state_q;
  logic [1:0] fault_q;
  logic flash_start_q;
  logic flash_busy;
  logic flash_done;
  logic flash_one;
  logic flash_two;
  logic cal_bad_q;
  logic [7:0] slot_char;
  logic cal_catch;
  logic self_hit;

  pst_fault_flasher #(
    .PULSE_CYC(PULSE_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_flasher (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(flash_start_q),
    .code_i(fault_q),
    .channel_one_indicator_o(flash_one),
    .channel_two_indicator_o(flash_two),
    .busy_o(flash_busy),
    .done_o(flash_done)
  );

  always_comb begin
    unique case (slot_i)
      PST_LEFT: slot_char = `PST_CHAR_L; // RL13
      PST_CENTER: slot_char = `PST_CHAR_C; // RL13
      PST_RIGHT: slot_char = `PST_CHAR_R; // RL13
      default: slot_char = `PST_CHAR_Q;
    endcase
  end

  // Indicators are re-registered so the top drives them from flip-flops.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      channel_one_indicator_o <= 1'b0;
      channel_two_indicator_o <= 1'b0;
    end else begin
      channel_one_indicator_o <= flash_one;
      channel_two_indicator_o <= flash_two;
    end
  end

  // Main sequence; a fault frame returns to the failing test or moves on.
  always_ff @(posedge clock_i) begin
    rom_start_o <= 1'b0;
    nvm_start_o <= 1'b0;
    sup_start_o <= 1'b0;
    flash_start_q <= 1'b0;
    settings_init_o <= 1'b0;
    recal_start_o <= 1'b0;
    if (sys_rst_i) begin
      state_q <= PST_ROM;
      fault_q <= 2'h0;
      link_enable_o <= 1'b0;
      self_run_o <= 1'b0;
      normal_o <= 1'b0;
      diag_menu_o <= 1'b0;
    end else begin
      unique case (state_q)
        PST_ROM: begin
          rom_start_o <= 1'b1; // RL1
          state_q <= PST_ROM_WAIT;
        end
        PST_ROM_WAIT: begin
          if (rom_done_i) begin
            if (rom_sum_calc_i != rom_sum_stored_i) begin // RL4
              fault_q <= `PST_CODE_ROM; // RL4
              flash_start_q <= 1'b1;
              state_q <= PST_FLASH;
            end else begin
              state_q <= PST_NVM; // RL1
            end
          end
        end
        PST_NVM: begin
          nvm_start_o <= 1'b1; // RL1
          state_q <= PST_NVM_WAIT;
        end
        PST_NVM_WAIT: begin
          if (nvm_done_i) begin
            if (nvm_fail_i) begin
              fault_q <= `PST_CODE_NVM; // RL7
              flash_start_q <= 1'b1;
              state_q <= PST_FLASH;
            end else begin
              state_q <= PST_SUP; // RL1
            end
          end
        end
        PST_SUP: begin
          sup_start_o <= 1'b1; // RL1
          state_q <= PST_SUP_WAIT;
        end
        PST_SUP_WAIT: begin
          if (sup_done_i) begin
            if (sup_signature_i != sup_good_sig_i) begin // RL9
              fault_q <= `PST_CODE_SUP; // RL9
              flash_start_q <= 1'b1;
              state_q <= PST_FLASH;
            end else begin
              state_q <= PST_INIT; // RL10
            end
          end
        end
        PST_FLASH: begin
          if (flash_done) begin
            unique case (fault_q)
              `PST_CODE_ROM: state_q <= PST_NVM; // RL5
              `PST_CODE_NVM: state_q <= PST_NVM; // RL7
              default: state_q <= PST_SUP; // RL9
            endcase
          end else if (!flash_busy && !flash_start_q) begin
            // Should a start go astray, ask again rather than hang here.
            flash_start_q <= 1'b1;
          end
        end
        PST_INIT: begin
          settings_init_o <= 1'b1; // RL10
          link_enable_o <= 1'b1; // RL10
          state_q <= PST_LINK;
        end
        PST_LINK: begin
          if (link_ready_i) begin
            if (self_req_i) begin // RL11
              self_run_o <= 1'b1;
              state_q <= PST_SELF;
            end else if (new_config_i) begin
              recal_start_o <= 1'b1;
              state_q <= PST_RECAL;
            end else begin
              normal_o <= 1'b1;
              state_q <= PST_NORMAL;
            end
          end
        end
        PST_SELF: begin
          if (self_done_i) begin
            self_run_o <= 1'b0;
            if (err_valid_o || self_err_i || panel_activity_i ||
                cal_bad_q) begin
              diag_menu_o <= 1'b1;
              state_q <= PST_DIAG;
            end else if (new_config_i) begin
              recal_start_o <= 1'b1; // RL16
              state_q <= PST_RECAL;
            end else begin
              normal_o <= 1'b1;
              state_q <= PST_NORMAL;
            end
          end
        end
        PST_RECAL: begin
          if (recal_done_i) begin
            if (recal_ok_i) begin
              normal_o <= 1'b1; // RL16
              state_q <= PST_NORMAL;
            end else begin
              diag_menu_o <= 1'b1;
              state_q <= PST_DIAG;
            end
          end
        end
        PST_NORMAL: state_q <= PST_NORMAL;
        PST_DIAG: state_q <= PST_DIAG;
        default: state_q <= PST_ROM;
      endcase
    end
  end

  // The test engine is told to keep calibration data intact from the first clock after reset.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      nvm_preserve_o <= 1'b0;
    end else begin
      nvm_preserve_o <= 1'b1; // RL6
    end
  end

  // A corrupt table is caught once, reloaded, and reported later.
  assign cal_catch = state_q == PST_NVM_WAIT && nvm_done_i && !nvm_fail_i &&
                     cal_sum_bad_i && !cal_bad_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cal_bad_q <= 1'b0;
    end else if (cal_catch) begin
      cal_bad_q <= 1'b1; // RL8
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cal_reload_o <= 1'b0;
    end else begin
      cal_reload_o <= cal_catch; // RL8
    end
  end

  // One self-test cycle may bring a reported fault, a touched panel, or,
  // at its close, the reloaded calibration table.
  assign self_hit = (state_q == PST_SELF) && (self_err_i ||
                    panel_activity_i || (self_done_i && cal_bad_q));

  // First error per block; later ones only add to the count.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      err_valid_o <= 1'b0;
      err_prefix_o <= 8'h00;
      err_code_o <= 16'h0000;
    end else if (self_hit && !err_valid_o) begin
      err_valid_o <= 1'b1; // RL15
      err_prefix_o <= slot_char; // RL12
      if (self_err_i) begin
        err_code_o <= self_code_i; // RL12
      end else if (panel_activity_i) begin
        err_code_o <= `PST_CODE_PANEL; // RL14
      end else begin
        err_code_o <= `PST_CODE_CAL; // RL8
      end
    end
  end

  // The count saturates; a wrapped count would read as few failures.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      err_count_o <= 8'h00;
    end else if (self_hit && err_count_o != 8'hFF) begin
      err_count_o <= err_count_o + 8'h01; // RL15
    end
  end

  // Monitor lines are latched once running so brief events are kept.
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      overload_seen_o <= 1'b0;
    end else if (state_q == PST_NORMAL) begin
      overload_seen_o <= overload_seen_o | overload_sense_i; // RL17
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      probe_seen_o <= 1'b0;
    end else if (state_q == PST_NORMAL) begin
      probe_seen_o <= probe_seen_o | probe_data_i; // RL17
    end
  end
endmodule
`default_nettype wire

// [verif/pst_mainframe_model.sv]
// Purpose: Mainframe and kernel test engines facing the reporter.
// Assumes: Verdicts arrive from the bench as levels.
// Notes: Answers after 2 or 6 cycles; idle sums wander so stale data shows.
`timescale 1ns/1ns
`default_nettype none
module pst_mainframe_model (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] start_i,
  input wire logic [3:0] bad_i,
  input wire logic link_enable_i,
  input wire logic slow_i,
  output logic [5:0] done_o,
  output logic [15:0] calc_o,
  output logic [15:0] sum_o,
  output logic [15:0] sig_o,
  output logic [15:0] good_o,
  output logic link_ready_o,
  output logic self_req_o
);
  localparam logic [15:0] SUM = 16'hA5C3;
  localparam logic [15:0] SIG = 16'h3C5A;
  logic [5:0] run_q;
  logic [5:0] pend_q;
  logic [2:0] cnt_q;
  logic [15:0] cyc_q;
  assign link_ready_o = link_enable_i;
  // Disabled mainframe self-tests mean no request at all.
  assign self_req_o = link_enable_i && !bad_i[3];
  assign calc_o = done_o[1] ? (bad_i[0] ? ~SUM : SUM) : cyc_q;
  assign sum_o = SUM;
  assign sig_o = done_o[3] ? (bad_i[2] ? ~SIG : SIG) : ~cyc_q;
  assign good_o = SIG;
  // One answer per new request; a level request counts once at its rise.
  always_ff @(posedge clock_i) begin
    done_o <= 6'h00;
    run_q <= start_i;
    cyc_q <= cyc_q + 16'h0001;
    if (sys_rst_i) begin
      cnt_q <= 3'h0;
      cyc_q <= 16'h0000;
    end else if (|(start_i & ~run_q)) begin
      pend_q <= start_i & ~run_q;
      cnt_q <= slow_i ? 3'h6 : 3'h2;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
      if (cnt_q == 3'h1) done_o <= pend_q;
    end
  end
endmodule
`default_nettype wire

// [verif/pst_selftest_top_sva.sv]
// Purpose: Port-level checks on the self-test fault reporter.
// Assumes: One clock, synchronous active-high reset.
// Notes: Done inputs only come in answer to a start.
`include "pst_defs.svh"
`timescale 1ns/1ns
`default_nettype none
module pst_selftest_top_chk (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic rom_done_i,
  input wire logic [15:0] rom_sum_calc_i,
  input wire logic [15:0] rom_sum_stored_i,
  input wire logic nvm_done_i,
  input wire logic nvm_fail_i,
  input wire pst_pkg::pst_slot_t slot_i,
  input wire logic self_done_i,
  input wire logic self_err_i,
  input wire logic panel_activity_i,
  input wire logic rom_start_o,
  input wire logic nvm_start_o,
  input wire logic nvm_preserve_o,
  input wire logic settings_init_o,
  input wire logic link_enable_o,
  input wire logic self_run_o,
  input wire logic channel_one_indicator_o,
  input wire logic channel_two_indicator_o,
  input wire logic err_valid_o,
  input wire logic [7:0] err_prefix_o,
  input wire logic [15:0] err_code_o,
  input wire logic [7:0] err_count_o
);
  import pst_pkg::*;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  a_rom_first: assert property (
    $fell(sys_rst_i) |-> ##[0:2] rom_start_o) else $error("no rom start");
  a_nvm_next: assert property (
    rom_done_i && rom_sum_calc_i == rom_sum_stored_i |-> ##[1:4] nvm_start_o)
    else $error("nvm test not next");
  a_rom_flash: assert property (
    rom_done_i && rom_sum_calc_i != rom_sum_stored_i
    |-> ##[1:8] channel_two_indicator_o) else $error("no fault frame");
  a_one_inside: assert property (
    channel_one_indicator_o |-> channel_two_indicator_o)
    else $error("channel one outside a pulse");
  a_nvm_no_link: assert property (
    nvm_done_i && nvm_fail_i |-> ##1 !link_enable_o [*8])
    else $error("link after nvm fault");
  a_link_after_init: assert property (
    $rose(link_enable_o) |-> settings_init_o || $past(settings_init_o))
    else $error("link before settings init");
  a_keep_first: assert property (
    err_valid_o |=> err_valid_o && $stable(err_code_o))
    else $error("first error code lost");
  a_count_step: assert property (
    self_run_o && self_err_i && !self_done_i && !panel_activity_i
    && err_count_o != 8'hFF |=> err_count_o == $past(err_count_o) + 8'h01)
    else $error("error count not stepped");
  a_prefix_right: assert property (
    err_valid_o && slot_i == PST_RIGHT |-> err_prefix_o == `PST_CHAR_R)
    else $error("prefix not right");
  a_preserve_nvm: assert property (
    !$past(sys_rst_i) |-> nvm_preserve_o) else $error("nvm data not kept");
endmodule
bind pst_selftest_top pst_selftest_top_chk chk (.clock_i, .sys_rst_i,
  .rom_done_i, .rom_sum_calc_i, .rom_sum_stored_i, .nvm_done_i, .nvm_fail_i,
  .slot_i, .self_done_i, .self_err_i, .panel_activity_i, .rom_start_o,
  .nvm_start_o, .nvm_preserve_o, .settings_init_o, .link_enable_o,
  .self_run_o, .channel_one_indicator_o, .channel_two_indicator_o,
  .err_valid_o, .err_prefix_o, .err_code_o, .err_count_o);
`default_nettype wire

// [verif/pst_selftest_top_bench.sv]
// Purpose: Self-checking bench for the self-test fault reporter.
// Assumes: Short pulse and pause counts of 4 and 8 cycles.
// Notes: Each run restarts from reset so looping faults end cleanly.
`timescale 1ns/1ns
`default_nettype none
module pst_selftest_top_bench;
  import pst_pkg::*;
  logic clock_i, sys_rst_i = 1'b1, cal_sum_bad_i = 1'b0, new_config_i = 1'b0;
  logic self_err_i = 1'b0, recal_ok_i = 1'b0, panel_activity_i = 1'b0;
  logic overload_sense_i = 1'b0, probe_data_i = 1'b0, slow = 1'b0;
  logic [3:0] bad = 4'h0;
  logic [15:0] self_code_i = 16'h0000;
  pst_slot_t slot_i = PST_LEFT;
  logic rom_done_i, nvm_done_i, nvm_fail_i, sup_done_i, link_ready_i;
  logic self_req_i, self_done_i, recal_done_i, reload_seen;
  logic [15:0] rom_sum_calc_i, rom_sum_stored_i, sup_signature_i;
  logic [15:0] sup_good_sig_i, err_code_o;
  logic rom_start_o, nvm_start_o, nvm_preserve_o, sup_start_o, cal_reload_o;
  logic settings_init_o, link_enable_o, self_run_o, recal_start_o, normal_o;
  logic diag_menu_o, channel_one_indicator_o, channel_two_indicator_o;
  logic err_valid_o, overload_seen_o, probe_seen_o;
  logic [7:0] err_prefix_o, err_count_o;
  logic [5:0] done;
  int err_count = 0, compares = 0;
  assign {recal_done_i, self_done_i, sup_done_i, nvm_done_i} = done[5:2];
  assign rom_done_i = done[1];
  assign nvm_fail_i = bad[1];
  pst_selftest_top #(.PULSE_CYC(4), .PAUSE_CYC(8)) dut (.*);
  pst_mainframe_model mf (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .start_i({recal_start_o, self_run_o, sup_start_o, nvm_start_o,
      rom_start_o, 1'b0}), .bad_i(bad), .link_enable_i(link_enable_o),
    .slow_i(slow), .done_o(done), .calc_o(rom_sum_calc_i),
    .sum_o(rom_sum_stored_i), .sig_o(sup_signature_i),
    .good_o(sup_good_sig_i), .link_ready_o(link_ready_i),
    .self_req_o(self_req_i));
  always @(posedge clock_i) reload_seen <= !sys_rst_i && (reload_seen |
    cal_reload_o);
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic start(input logic [3:0] b, input logic s,
                       input pst_slot_t sl, input logic cal, input logic nc);
    @(negedge clock_i);
    {sys_rst_i, bad, slow, cal_sum_bad_i, new_config_i} = {1'b1, b, s, cal, nc};
    slot_i = sl;
    repeat (4) @(negedge clock_i);
    sys_rst_i = 1'b0;
  endtask
  // Bounded wait; the loop stops on the first negedge that shows the level.
  task automatic wait_for(input int w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 400 && !hit; i++) begin
      @(negedge clock_i);
      case (w)
        0: hit = normal_o === 1'b1;
        1: hit = diag_menu_o === 1'b1;
        2: hit = self_run_o === 1'b1;
        3: hit = nvm_start_o === 1'b1;
        default: hit = sup_start_o === 1'b1;
      endcase
    end
    if (!hit) begin
      err_count++;
      $display("[ERR] t=%0t wait %0d ran out", $time, w);
      final_report;
    end
  endtask
  // A dark spell longer than a pulse gap marks the end of the frame.
  task automatic frame(input int code);
    int n, lit, dark;
    n = 0;
    lit = 0;
    dark = 1;
    for (int i = 0; i < 300 && !(n > 0 && dark > 6); i++) begin
      @(negedge clock_i);
      if (channel_two_indicator_o === 1'b1 && dark > 0) n++;
      if (channel_one_indicator_o === 1'b1 && lit == 0) lit = n;
      dark = (channel_two_indicator_o === 1'b1) ? 0 : dark + 1;
    end
    if (!(n > 0 && dark > 6)) begin
      err_count++;
      $display("[ERR] t=%0t frame never closed", $time);
      final_report;
    end
    check(16'(n), 16'h0008);
    check(16'(lit), 16'(code));
  endtask
  task automatic t_clean;
    start(4'h0, 1'b0, PST_CENTER, 1'b0, 1'b0);
    wait_for(0);
    check({err_valid_o, reload_seen, nvm_preserve_o}, 3'b001);
    {overload_sense_i, probe_data_i} = 2'b11;
    repeat (2) @(negedge clock_i);
    check({overload_seen_o, probe_seen_o}, 2'b11);
    {overload_sense_i, probe_data_i} = 2'b00;
  endtask
  task automatic t_faults;
    for (int c = 1; c < 4; c++) begin
      start(4'(1 << (c - 1)), c == 2, PST_LEFT, 1'b0, 1'b0);
      frame(c);
      wait_for(c == 1 ? 0 : c + 1);
      check(link_enable_o, c == 1);
    end
  endtask
  task automatic t_self_err;
    start(4'h0, 1'b1, PST_RIGHT, 1'b1, 1'b0);
    wait_for(2);
    self_err_i = 1'b1;
    self_code_i = 16'h1311;
    @(negedge clock_i);
    self_code_i = 16'h1811;
    @(negedge clock_i);
    self_err_i = 1'b0;
    wait_for(1);
    check(err_prefix_o, 8'h52);
    check(err_code_o, 16'h1311);
    check(err_count_o, 8'h03);
    check(reload_seen, 1'b1);
  endtask
  task automatic t_panel;
    for (int s = 0; s < 2; s++) begin
      start(4'h0, 1'b1, s ? PST_CENTER : PST_LEFT, s == 1, 1'b0);
      wait_for(2);
      panel_activity_i = s == 0;
      @(negedge clock_i);
      panel_activity_i = 1'b0;
      wait_for(1);
      check(err_prefix_o, s ? 8'h43 : 8'h4C);
      check(err_code_o, s ? 16'h1231 : 16'h1911);
      check(err_count_o, 8'h01);
    end
  endtask
  task automatic t_recal;
    for (int k = 0; k < 2; k++) begin
      recal_ok_i = k == 0;
      start(4'h8, 1'b0, PST_CENTER, 1'b0, 1'b1);
      wait_for(k);
      check(self_run_o, 1'b0);
    end
  endtask
  initial begin
    t_clean;
    t_faults;
    t_self_err;
    t_panel;
    t_recal;
    final_report;
  end
endmodule
`default_nettype wire
